/* ptm_pkg.sv */
// shared constants, types and register map of the path trace monitor
// assumes a 20 MHz system clock and an axi4-lite master on the register side
package ptm_pkg;
	localparam int CLK_HZ          = 20_000_000; // system clock rate
	localparam int REFRESH_S       = 2;          // management view refresh, seconds
	localparam int REFRESH_CYC_DEF = REFRESH_S * CLK_HZ;
	localparam int PERSIST_DEF     = 3;          // identical messages before accept
	localparam int SHORT_LEN       = 16;         // short trace format, bytes
	localparam int LONG_LEN        = 64;         // long trace format, bytes

	localparam logic [7:0] CHAR_NULL = 8'h00;
	localparam logic [7:0] CHAR_CR   = 8'h0d;
	localparam logic [7:0] CHAR_LF   = 8'h0a;

	// register byte addresses and string regions (addr[11:8])
	localparam logic [11:0] OFF_CTRL = 12'h000;
	localparam logic [11:0] OFF_STAT = 12'h004;
	localparam logic [11:0] OFF_IST  = 12'h008;
	localparam logic [11:0] OFF_IMSK = 12'h00c;
	localparam logic [3:0]  RGN_TX   = 4'h1; // transmit string, rw
	localparam logic [3:0]  RGN_EXP  = 4'h2; // expected string, rw
	localparam logic [3:0]  RGN_EXPV = 4'h3; // expected view, ro
	localparam logic [3:0]  RGN_RXV  = 4'h4; // received view, ro

	// control field positions
	localparam int CTL_MODE    = 0; // two bits
	localparam int CTL_TIM_SUP = 2;
	localparam int CTL_SLM_SUP = 3;
	localparam int CTL_TX16    = 4;
	localparam int CTL_EXP16   = 5;
	localparam int CTL_DEFAULT = 8;
	localparam int CTL_RELEARN = 9;

	// interrupt status bits
	localparam int IRQ_RAISE = 0;
	localparam int IRQ_CLEAR = 1;
	localparam int IRQ_RXNEW = 2;
	localparam logic [2:0] IRQ_RESET = 3'h0;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	typedef enum logic [1:0] {
		PTM_OFF    = 2'b00,
		PTM_AUTO   = 2'b01,
		PTM_MANUAL = 2'b10
	} ptm_mode_t;

	typedef logic [63:0][7:0] ptm_str_t; // one trace, byte 0 first

	// per-frame trace byte slot from the framer
	typedef struct packed {
		logic       strobe;
		logic [7:0] rx_byte;
	} ptm_j1_in_t;

	// alarm and consequent-action levels to the path overhead logic
	typedef struct packed {
		logic mismatch;
		logic ais_sup;
		logic rdi_sup;
	} ptm_alarm_t;

	typedef struct packed {
		logic [5:0] idx;
		logic [7:0] tx_byte;
	} ptm_tx_st_t;

	typedef struct packed {
		logic [5:0] idx;
		logic       start16;
		logic       diff;
		logic [7:0] prev;
		logic [2:0] same;
		logic       fmt16;
		logic       valid;
		ptm_str_t   cand;
	} ptm_rx_st_t;

	typedef struct packed {
		logic        awg;
		logic        wg;
		logic [11:0] awaddr;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [1:0]  rresp;
		logic [31:0] rdata;
		ptm_mode_t   mode;
		logic        tim_sup;
		logic        slm_sup;
		logic        tx16;
		logic        exp16;
		logic        tx_set;
		logic        learned;
		logic        mism;
		logic        acc16;
		logic [2:0]  ist;
		logic [2:0]  imsk;
		logic [31:0] rcnt;
		ptm_str_t    tx;
		ptm_str_t    exp;
		ptm_str_t    acc;
		ptm_str_t    expv;
		ptm_str_t    rxv;
	} ptm_st_t;
endpackage

/* ptm_tx_insert.sv */
// transmit side: drives one trace byte per frame slot
// assumes strobe comes from framer logic on clk_sys
module ptm_tx_insert
	import ptm_pkg::*;
(
	input  wire logic       clk_sys,
	input  wire logic       resetn,
	input  wire logic       strobe,
	input  wire logic       tx_set,
	input  wire logic       len16,
	input  wire ptm_str_t   str,
	output logic      [7:0] tx_byte
);
	ptm_tx_st_t r;   // registered state
	ptm_tx_st_t n;   // next state

	// pick the byte for this slot and advance the position
	always_comb
	begin
		n = r;
		if (strobe)
		begin
			n.tx_byte = tx_set ? str[r.idx] : CHAR_NULL;
			// a switch to the short length while past byte 15 wraps at once
			if ((len16 && r.idx >= 6'(SHORT_LEN - 1)) || r.idx == 6'(LONG_LEN - 1))
				n.idx = 6'h00;
			else
				n.idx = r.idx + 6'h01;
		end
	end

	// state register
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
			r <= '0;
		else
			r <= n;
	end

	assign tx_byte = r.tx_byte;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);

	null_trace_a: assert property (strobe && !tx_set |=> tx_byte == CHAR_NULL)
		else $error("unprovisioned trace byte not null");
endmodule

/* ptm_rx_capture.sv */
// receive side: aligns, sizes and validates the incoming trace message
// assumes strobe and rx_byte come from framer logic on clk_sys
module ptm_rx_capture
	import ptm_pkg::*;
#(
	parameter int PERSIST = PERSIST_DEF
)
(
	input  wire logic     clk_sys,
	input  wire logic     resetn,
	input  wire logic     strobe,
	input  wire logic [7:0] rx_byte,
	output logic          msg_valid,
	output logic          msg16,
	output ptm_str_t      msg
);
	ptm_rx_st_t r;   // registered state
	ptm_rx_st_t n;   // next state

	// byte position, format start marker and message end detection
	always_comb
	begin
		logic [5:0] pos;
		logic       dif;
		logic       st16;
		logic       end16;
		logic       end64;
		pos   = '0;
		dif   = 1'b0;
		st16  = 1'b0;
		end16 = 1'b0;
		end64 = 1'b0;
		n = r;
		n.valid = 1'b0;
		if (strobe)
		begin
			pos   = rx_byte[7] ? 6'h00 : r.idx;
			st16  = rx_byte[7] | r.start16;
			dif   = ((pos == 6'h00) ? 1'b0 : r.diff) | (r.cand[pos] != rx_byte);
			end16 = st16 && pos == 6'(SHORT_LEN - 1);
			end64 = !st16 && r.prev == CHAR_CR && rx_byte == CHAR_LF
				&& pos == 6'(LONG_LEN - 1);
			n.prev      = rx_byte;
			n.cand[pos] = rx_byte;
			n.diff      = dif;
			n.start16   = st16;
			n.idx       = pos + 6'h01;
			if (end16 || end64)
			begin
				n.idx     = 6'h00;
				n.start16 = 1'b0;
				n.fmt16   = end16;
				if (!dif && r.fmt16 == end16)
					n.same = (r.same >= 3'(PERSIST)) ? r.same : r.same + 3'h1;
				else
					n.same = 3'h1;
				n.valid = (n.same >= 3'(PERSIST));
			end
			else if (pos == 6'(LONG_LEN - 1))
			begin
				// no end marker: drop alignment and start over
				n.idx     = 6'h00;
				n.start16 = 1'b0;
			end
		end
	end

	// state register
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
			r <= '0;
		else
			r <= n;
	end

	assign msg_valid = r.valid;
	assign msg16     = r.fmt16;
	assign msg       = r.cand;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);

	long_fmt_a: assert property (strobe && !rx_byte[7] && !r.start16 && r.idx == 6'h3f
		&& r.prev == CHAR_CR && rx_byte == CHAR_LF |=> !msg16)
		else $error("long format end not detected");
	persist_gate_a: assert property (msg_valid |-> r.same >= 3'(PERSIST) && $past(strobe))
		else $error("message accepted before persistence");
endmodule

/* ptm_path_trace.sv */
// path trace monitor top: registers, baseline, mismatch alarm, views
// assumes an axi4-lite master on clk_sys and a framer giving one slot per frame
//
// The AXI4-Lite slave port and the address map were left to the implementer.
module ptm_path_trace
	import ptm_pkg::*;
#(
	parameter int REFRESH_CYC = REFRESH_CYC_DEF,
	parameter int PERSIST     = PERSIST_DEF
)
(
	input  wire logic        clk_sys,
	input  wire logic        resetn,
	input  wire logic [11:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [11:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire ptm_j1_in_t  j1_in,
	output logic [7:0]       j1_tx_byte,
	input  wire logic        c2_mismatch,
	output ptm_alarm_t       alarm,
	output logic             irq
);
	ptm_st_t    r;        // registered state
	ptm_st_t    n;        // next state
	logic       rx_valid; // accepted message pulse
	logic       rx16;     // accepted message is short format
	ptm_str_t   rx_msg;   // accepted message bytes

	// address lies in the implemented map
	function automatic logic is_mapped(input logic [11:0] a);
		logic ok;
		ok = 1'b0;
		if (a[11:8] == 4'h0)
			ok = (a[7:4] == 4'h0);
		else if (a[11:8] >= RGN_TX && a[11:8] <= RGN_RXV)
			ok = (a[7:6] == 2'b00);
		return ok;
	endfunction

	// four string bytes as one bus word, lowest byte in the low lane
	function automatic logic [31:0] str_word(input ptm_str_t s, input logic [3:0] w);
		return {s[{w, 2'd3}], s[{w, 2'd2}], s[{w, 2'd1}], s[{w, 2'd0}]};
	endfunction

	// true when a received trace differs from the baseline
	function automatic logic differs(
		input ptm_str_t a,
		input logic     a16,
		input ptm_str_t b,
		input logic     b16
	);
		logic d;
		d = (a16 != b16);
		for (int i = 0; i < LONG_LEN; i++)
		begin
			if (!a16 || i < SHORT_LEN)
				d = d | (a[i] != b[i]);
		end
		return d;
	endfunction

	// register read decode
	function automatic logic [31:0] rd_word(input ptm_st_t s, input logic [11:0] a,
		input logic f16);
		logic [31:0] v;
		v = '0;
		case (a[11:8])
			4'h0:
			begin
				case (a)
					OFF_CTRL: v = {26'h0, s.exp16, s.tx16, s.slm_sup, s.tim_sup, s.mode};
					OFF_STAT: v = {26'h0, s.mode, s.tx_set, s.learned, f16, s.mism};
					OFF_IST:  v = {29'h0, s.ist};
					OFF_IMSK: v = {29'h0, s.imsk};
					default:  v = '0;
				endcase
			end
			RGN_TX:   v = str_word(s.tx, a[5:2]);
			RGN_EXP:  v = str_word(s.exp, a[5:2]);
			RGN_EXPV: v = str_word(s.expv, a[5:2]);
			RGN_RXV:  v = str_word(s.rxv, a[5:2]);
			default:  v = '0;
		endcase
		return v;
	endfunction

	// trace byte insertion on the transmit path
	ptm_tx_insert u_tx (
		.clk_sys (clk_sys),
		.resetn  (resetn),
		.strobe  (j1_in.strobe),
		.tx_set  (r.tx_set),
		.len16   (r.tx16),
		.str     (r.tx),
		.tx_byte (j1_tx_byte)
	);

	// trace capture and format detection on the receive path
	ptm_rx_capture #(
		.PERSIST (PERSIST)
	) u_rx (
		.clk_sys   (clk_sys),
		.resetn    (resetn),
		.strobe    (j1_in.strobe),
		.rx_byte   (j1_in.rx_byte),
		.msg_valid (rx_valid),
		.msg16     (rx16),
		.msg       (rx_msg)
	);

	// bus handshakes: one write and one read outstanding at most
	assign s_axi_awready = !r.awg && !r.bvalid;
	assign s_axi_wready  = !r.wg && !r.bvalid;
	assign s_axi_arready = !r.rvalid;
	assign s_axi_bvalid  = r.bvalid;
	assign s_axi_bresp   = r.bresp;
	assign s_axi_rvalid  = r.rvalid;
	assign s_axi_rresp   = r.rresp;
	assign s_axi_rdata   = r.rdata;

	// next state: bus slave, register writes, trace checking, views
	always_comb
	begin
		logic [3:0] w;
		logic [2:0] ev;
		w  = '0;
		ev = '0;
		n  = r;
		// address and data may arrive in either order
		if (s_axi_awvalid && s_axi_awready)
		begin
			n.awg    = 1'b1;
			n.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			n.wg    = 1'b1;
			n.wdata = s_axi_wdata;
			n.wstrb = s_axi_wstrb;
		end
		if (s_axi_bvalid && s_axi_bready)
			n.bvalid = 1'b0;
		// both halves held: perform the write
		if (r.awg && r.wg)
		begin
			n.awg    = 1'b0;
			n.wg     = 1'b0;
			n.bvalid = 1'b1;
			n.bresp  = is_mapped(r.awaddr) ? RESP_OKAY : RESP_DECERR;
			w        = r.awaddr[5:2];
			if (r.awaddr == OFF_CTRL && r.wstrb[0])
			begin
				n.mode    = ptm_mode_t'(r.wdata[CTL_MODE +: 2]);
				n.tim_sup = r.wdata[CTL_TIM_SUP];
				n.slm_sup = r.wdata[CTL_SLM_SUP];
				n.tx16    = r.wdata[CTL_TX16];
				n.exp16   = r.wdata[CTL_EXP16];
			end
			if (r.awaddr == OFF_CTRL && r.wstrb[1])
			begin
				// relearn drops the learned baseline
				if (r.wdata[CTL_RELEARN])
					n.learned = 1'b0;
				if (r.wdata[CTL_DEFAULT])
				begin
					n.mode    = PTM_OFF;
					n.tx      = '0;
					n.exp     = '0;
					n.tx_set  = 1'b0;
					n.learned = 1'b0;
				end
			end
			if (r.awaddr == OFF_IST && r.wstrb[0])
				n.ist = r.ist & ~r.wdata[2:0];
			if (r.awaddr == OFF_IMSK && r.wstrb[0])
				n.imsk = r.wdata[2:0];
			// string writes, byte lanes honoured
			for (int b = 0; b < 4; b++)
			begin
				if (r.wstrb[b] && r.awaddr[11:8] == RGN_TX && r.awaddr[7:6] == 2'b00)
				begin
					n.tx[{w, 2'(b)}] = r.wdata[8*b +: 8];
					n.tx_set = 1'b1;
				end
				if (r.wstrb[b] && r.awaddr[11:8] == RGN_EXP && r.awaddr[7:6] == 2'b00)
					n.exp[{w, 2'(b)}] = r.wdata[8*b +: 8];
			end
		end
		// reads answer one cycle after the address is taken
		if (s_axi_rvalid && s_axi_rready)
			n.rvalid = 1'b0;
		if (s_axi_arvalid && s_axi_arready)
		begin
			n.rvalid = 1'b1;
			n.rdata  = rd_word(r, s_axi_araddr, rx16);
			n.rresp  = is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_DECERR;
		end
		// trace checking on each accepted message
		if (n.mode == PTM_OFF)
		begin
			n.mism    = 1'b0;
			n.learned = 1'b0;
		end
		else if (rx_valid)
		begin
			ev[IRQ_RXNEW] = 1'b1;
			n.acc   = rx_msg;
			n.acc16 = rx16;
			if (n.mode == PTM_AUTO && !n.learned)
			begin
				n.exp     = rx_msg;
				n.exp16   = rx16;
				n.learned = 1'b1;
				n.mism    = 1'b0;
			end
			else
			begin
				n.mism = differs(rx_msg, rx16, n.exp, n.exp16);
			end
		end
		ev[IRQ_RAISE] = n.mism && !r.mism;
		ev[IRQ_CLEAR] = !n.mism && r.mism;
		// hardware events win over a same-cycle clear
		n.ist = n.ist | ev;
		if (n.mode == PTM_OFF)
			n.rcnt = '0;
		else if (r.rcnt == '0)
		begin
			n.rcnt = 32'(REFRESH_CYC - 1);
			n.expv = r.exp;
			n.rxv  = r.acc;
		end
		else
			n.rcnt = r.rcnt - 32'h1;
	end

	// state register
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			r      <= '0;
			r.mode <= PTM_OFF;
			r.ist  <= IRQ_RESET;
			r.imsk <= IRQ_RESET;
		end
		else
			r <= n;
	end

	assign alarm.mismatch = r.mism;
	assign alarm.rdi_sup  = r.tim_sup && r.mism;
	assign alarm.ais_sup  = (r.tim_sup && r.mism) || (r.slm_sup && c2_mismatch);
	assign irq            = |(r.ist & r.imsk);

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);

	sequence learn_s;
		r.mode == PTM_AUTO && !r.learned && rx_valid && n.mode == PTM_AUTO;
	endsequence

	// next-state baseline, so a same-cycle relearn or string write is seen
	sequence bad_rx_s;
		n.learned && rx_valid && differs(rx_msg, rx16, n.exp, n.exp16);
	endsequence

	auto_learn_a: assert property (learn_s |=> r.learned && !alarm.mismatch
		&& r.exp == $past(rx_msg))
		else $error("first trace not learned");
	auto_mism_a: assert property ((r.mode == PTM_AUTO && n.mode == PTM_AUTO) and bad_rx_s
		|=> alarm.mismatch)
		else $error("auto mismatch not raised");
	manual_cmp_a: assert property (r.mode == PTM_MANUAL && n.mode == PTM_MANUAL
		&& rx_valid |=> alarm.mismatch == differs($past(rx_msg), $past(rx16),
		$past(n.exp), $past(n.exp16)))
		else $error("manual compare wrong");
	tim_sup_a: assert property (alarm.mismatch && r.tim_sup |-> alarm.rdi_sup
		&& alarm.ais_sup)
		else $error("suppression on mismatch missing");
	slm_sup_a: assert property (r.slm_sup && c2_mismatch |-> alarm.ais_sup)
		else $error("signal label suppression missing");
	defaults_a: assert property (r.awg && r.wg && r.awaddr == OFF_CTRL && r.wstrb[1]
		&& r.wdata[CTL_DEFAULT] |=> r.mode == PTM_OFF && !r.tx_set && r.tx == '0)
		else $error("defaults not restored");
	view_tick_a: assert property (r.mode != PTM_OFF && n.mode != PTM_OFF
		&& r.rcnt == '0 |=> r.rxv == $past(r.acc) && r.expv == $past(r.exp))
		else $error("views not refreshed");
	irq_set_a: assert property (alarm.mismatch && !$past(alarm.mismatch)
		|-> r.ist[IRQ_RAISE])
		else $error("raise event lost");
endmodule

/* ptm_far_end.sv */
// far-end path terminating port: sends a trace string, one byte per frame slot
// assumes it shares clk_sys and resetn with the monitor under test
module ptm_far_end
	import ptm_pkg::*;
(
	input  wire logic     clk_sys,
	input  wire logic     resetn,
	input  wire logic     run,
	input  wire logic     slow,
	input  wire logic     len16,
	input  wire ptm_str_t msg,
	output ptm_j1_in_t    j1_in,
	output int            msg_cnt
);
	timeunit 1ns;
	timeprecision 1ns;

	ptm_str_t   cur;   // message now on the line
	logic       cur16; // message now on the line is short
	logic [5:0] idx;   // next byte to send
	logic [1:0] gap;   // idle slots left before the next byte
	logic       go;    // a byte goes out at this edge

	assign go = run && gap == 2'h0;

	// one byte a slot; between slots the byte line toggles so nothing stale shows
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			j1_in   <= '0;
			cur     <= '0;
			cur16   <= 1'b0;
			idx     <= 6'h00;
			gap     <= 2'h0;
			msg_cnt <= 0;
		end
		else
		begin
			j1_in.strobe  <= go;
			j1_in.rx_byte <= go ? cur[idx] : ~j1_in.rx_byte;
			if (!go)
				gap <= (gap == 2'h0) ? 2'h0 : gap - 2'h1;
			else
			begin
				gap <= slow ? 2'h3 : 2'h0;
				// a new string is taken only between whole messages
				if (idx == (cur16 ? 6'h0f : 6'h3f))
				begin
					idx     <= 6'h00;
					cur     <= msg;
					cur16   <= len16;
					msg_cnt <= msg_cnt + 1;
				end
				else
					idx <= idx + 6'h01;
			end
		end
	end
endmodule

/* tb_ptm_path_trace.sv */
// self-checking bench of the path trace monitor, far-end model on the trace slot
// assumes the package, the design and the far-end model are compiled before it
`define CHK(g, e) check_eq(64'(g), 64'(e))
module tb_ptm_path_trace
	import ptm_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	localparam int P   = PERSIST_DEF; // identical messages before accept
	localparam int TMO = 20000;       // cycle ceiling of the run

	logic        clk_sys       = 1'b0;
	logic        resetn        = 1'b0;
	logic [11:0] s_axi_awaddr  = 12'h000;
	logic        s_axi_awvalid = 1'b0;
	logic        s_axi_awready;
	logic [31:0] s_axi_wdata   = 32'h0;
	logic [3:0]  s_axi_wstrb   = 4'hf;
	logic        s_axi_wvalid  = 1'b0;
	logic        s_axi_wready;
	logic [1:0]  s_axi_bresp;
	logic        s_axi_bvalid;
	logic        s_axi_bready  = 1'b0;
	logic [11:0] s_axi_araddr  = 12'h000;
	logic        s_axi_arvalid = 1'b0;
	logic        s_axi_arready;
	logic [31:0] s_axi_rdata;
	logic [1:0]  s_axi_rresp;
	logic        s_axi_rvalid;
	logic        s_axi_rready  = 1'b0;
	ptm_j1_in_t  j1_in;
	logic [7:0]  j1_tx_byte;
	logic        c2_mismatch   = 1'b0;
	ptm_alarm_t  alarm;
	logic        irq;
	logic        fe_run        = 1'b0; // far end sending
	logic        fe_slow       = 1'b0; // far end spaces its bytes
	logic        fe_16         = 1'b0; // far end uses the short format
	ptm_str_t    fe_msg        = '0;   // string the far end sends
	int          fe_cnt;               // messages sent so far
	int          failures      = 0;
	int          n_compared    = 0;
	int          cyc           = 0;
	logic [31:0] rd;                   // last read data
	logic [1:0]  rr;                   // last read response

	ptm_path_trace #(.REFRESH_CYC(20), .PERSIST(P)) u_dut
	(
		.clk_sys, .resetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .j1_in,
		.j1_tx_byte, .c2_mismatch, .alarm, .irq
	);

	ptm_far_end u_far
	(
		.clk_sys, .resetn, .run(fe_run), .slow(fe_slow), .len16(fe_16),
		.msg(fe_msg), .j1_in, .msg_cnt(fe_cnt)
	);

	// free-running clock, 50 ns period
	always #25 clk_sys = ~clk_sys;

	// run ceiling: a hang counts as a mismatch
	always @(posedge clk_sys)
	begin
		cyc <= cyc + 1;
		if (cyc == TMO)
		begin
			failures++;
			$display("BAD t=%0t run timed out", $time);
			final_report();
		end
	end

	task automatic final_report();
		$display("compared %0d mismatched %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic check_eq(input logic [63:0] g, input logic [63:0] e);
		n_compared++;
		if (g !== e)
		begin
			failures++;
			$display("BAD t=%0t got %0h expected %0h", $time, g, e);
		end
	endtask

	// one write: address and data offered together, each released when taken
	task automatic axi_wr(input logic [11:0] a, input logic [31:0] d);
		logic aw_ok;
		logic w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		@(posedge clk_sys);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(aw_ok && w_ok))
		begin
			@(posedge clk_sys);
			if (!aw_ok && s_axi_awready)
			begin
				aw_ok = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (!w_ok && s_axi_wready)
			begin
				w_ok = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		do
			@(posedge clk_sys);
		while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
	endtask

	// one read: result lands in rd and rr
	task automatic axi_rd(input logic [11:0] a);
		@(posedge clk_sys);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
			@(posedge clk_sys);
		while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do
			@(posedge clk_sys);
		while (!s_axi_rvalid);
		rd = s_axi_rdata;
		rr = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask

	task automatic rd_chk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
		axi_rd(a);
		`CHK({rr, rd & m}, {RESP_OKAY, e});
	endtask

	function automatic logic [31:0] word(input ptm_str_t s, input int k);
		return 32'(s[4 * k +: 4]);
	endfunction

	// long format: seven-bit characters, closed by carriage return and line feed
	function automatic ptm_str_t mk64(input logic [7:0] c);
		ptm_str_t s;
		for (int i = 0; i < 62; i++)
			s[i] = c + 8'(i);
		s[62] = CHAR_CR;
		s[63] = CHAR_LF;
		return s;
	endfunction

	// short format: first byte marked by its top bit
	function automatic ptm_str_t mk16(input logic [7:0] c);
		ptm_str_t s;
		s = '0;
		s[0] = 8'h80 | c;
		for (int i = 1; i < 16; i++)
			s[i] = c + 8'(i);
		return s;
	endfunction

	task automatic wr_str(input logic [3:0] g, input ptm_str_t s, input int n);
		for (int k = 0; k < n / 4; k++)
			axi_wr({g, 8'(4 * k)}, word(s, k));
	endtask

	// new string follows the message now in flight
	task automatic set_msg(input ptm_str_t m, input logic l16);
		int s;
		s = fe_cnt;
		while (fe_cnt == s)
			@(posedge clk_sys);
		fe_msg <= m;
		fe_16 <= l16;
	endtask

	task automatic wait_msgs(input int n);
		int s;
		s = fe_cnt;
		while (fe_cnt < s + n)
			@(posedge clk_sys);
		repeat (4) @(posedge clk_sys);
	endtask

	// reset state, unmapped address, null transmit trace
	task automatic t_reset();
		`CHK({alarm, irq}, 4'h0);
		rd_chk(OFF_CTRL, 32'hffffffff, 32'h0);
		rd_chk(OFF_STAT, 32'hffffffff, 32'h0);
		axi_rd(12'h010);
		`CHK({rr, rd}, {RESP_DECERR, 32'h0});
		fe_run <= 1'b1;
		repeat (200)
		begin
			@(posedge clk_sys);
			`CHK(j1_tx_byte, 8'h00);
		end
	endtask

	// learn, persist, mismatch with suppression, interrupt, views
	task automatic t_auto();
		axi_wr(OFF_IMSK, 32'h1);
		set_msg(mk64(8'h41), 1'b0);
		axi_wr(OFF_CTRL, 32'h5);
		wait_msgs(P + 2);
		`CHK({alarm, irq}, 4'h0);
		rd_chk(OFF_STAT, 32'h5, 32'h4);
		rd_chk(OFF_STAT, 32'h2, 32'h0);
		rd_chk({RGN_EXP, 8'h3c}, 32'hffffffff, word(mk64(8'h41), 15));
		set_msg(mk64(8'h30), 1'b0);
		wait_msgs(P);
		`CHK(alarm.mismatch, 1'b0);
		wait_msgs(1);
		`CHK({alarm, irq}, 4'hf);
		rd_chk(OFF_IST, 32'h7, 32'h5);
		axi_wr(OFF_IST, 32'h7);
		`CHK(irq, 1'b0);
		repeat (50) @(posedge clk_sys);
		rd_chk({RGN_RXV, 8'h00}, 32'hffffffff, word(mk64(8'h30), 0));
		rd_chk({RGN_EXPV, 8'h00}, 32'hffffffff, word(mk64(8'h41), 0));
		// relearn: the string now arriving becomes the baseline, alarm clears
		axi_wr(OFF_CTRL, 32'h205);
		wait_msgs(2);
		`CHK(alarm.mismatch, 1'b0);
		rd_chk(OFF_IST, 32'h2, 32'h2);
		rd_chk({RGN_EXP, 8'h00}, 32'hffffffff, word(mk64(8'h30), 0));
	endtask

	// defaults, signal label option, manual baseline
	task automatic t_manual();
		axi_wr(OFF_CTRL, 32'h100);
		rd_chk(OFF_CTRL, 32'h103, 32'h0);
		rd_chk(OFF_STAT, 32'h3d, 32'h0);
		rd_chk({RGN_EXP, 8'h00}, 32'hffffffff, 32'h0);
		`CHK(alarm, 3'h0);
		axi_wr(OFF_CTRL, 32'h8);
		c2_mismatch <= 1'b1;
		@(posedge clk_sys);
		`CHK(alarm, 3'h2);
		axi_wr(OFF_CTRL, 32'h0);
		`CHK(alarm, 3'h0);
		c2_mismatch <= 1'b0;
		wr_str(RGN_EXP, mk64(8'h30), 64);
		axi_wr(OFF_CTRL, 32'h2);
		wait_msgs(P + 1);
		`CHK(alarm, 3'h0);
		set_msg(mk64(8'h41), 1'b0);
		wait_msgs(P + 1);
		`CHK(alarm, 3'h4);
	endtask

	// short received format found unaided; short provisioned transmit string
	task automatic t_short();
		ptm_str_t   t;
		logic [7:0] b [32];
		logic [3:0] off;
		axi_wr(OFF_CTRL, 32'h100);
		fe_slow <= 1'b1;
		set_msg(mk16(8'h51), 1'b1);
		// let the long message in flight pass before auto mode starts
		set_msg(mk16(8'h51), 1'b1);
		axi_wr(OFF_CTRL, 32'h1);
		wait_msgs(P + 2);
		rd_chk(OFF_STAT, 32'h7, 32'h6);
		rd_chk({RGN_EXP, 8'h00}, 32'hffffffff, word(mk16(8'h51), 0));
		t = '0;
		for (int i = 0; i < 16; i++)
			t[i] = 8'h60 + 8'(i);
		wr_str(RGN_TX, t, 16);
		axi_wr(OFF_CTRL, 32'h11);
		rd_chk(OFF_STAT, 32'h8, 32'h8);
		for (int i = 0; i < 52; i++)
		begin
			do
				@(posedge clk_sys);
			while (!j1_in.strobe);
			repeat (2) @(posedge clk_sys);
			if (i >= 20)
				b[i - 20] = j1_tx_byte;
		end
		off = b[0][3:0];
		for (int i = 0; i < 32; i++)
			`CHK(b[i], {4'h6, 4'(off + 4'(i))});
	endtask

	initial
	begin
		repeat (8) @(posedge clk_sys);
		resetn <= 1'b1;
		@(posedge clk_sys);
		t_reset();
		t_auto();
		t_manual();
		t_short();
		final_report();
	end
endmodule
